// ### src/mts_pkg.sv
// Constants, field layouts and carrier types of the measurement trigger sequencer
`default_nettype none
package mts_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] MTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] MTS_COUNT_OFS = 8'h04;
  localparam logic [7:0] MTS_TIMER_OFS = 8'h08;
  localparam logic [7:0] MTS_CMD_OFS = 8'h0C;
  localparam logic [7:0] MTS_STATUS_OFS = 8'h10;
  localparam logic [7:0] MTS_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] MTS_IRQ_MASK_OFS = 8'h18;

  // ****************************************
  // Event selections
  // ****************************************
  localparam logic [2:0] MTS_ARM_AUTO = 3'h0;
  localparam logic [2:0] MTS_ARM_EXT = 3'h1;
  localparam logic [2:0] MTS_ARM_ONE = 3'h2;
  localparam logic [2:0] MTS_ARM_HOLD = 3'h3;
  localparam logic [2:0] MTS_TRIG_AUTO = 3'h0;
  localparam logic [2:0] MTS_TRIG_EXT = 3'h1;
  localparam logic [2:0] MTS_TRIG_LEVEL = 3'h2;
  localparam logic [2:0] MTS_TRIG_LINE = 3'h3;
  localparam logic [2:0] MTS_TRIG_REQ = 3'h4;
  localparam logic [2:0] MTS_TRIG_ONE = 3'h5;
  localparam logic [2:0] MTS_TRIG_HOLD = 3'h6;
  localparam logic [2:0] MTS_SAMP_AUTO = 3'h0;
  localparam logic [2:0] MTS_SAMP_EXT = 3'h1;
  localparam logic [2:0] MTS_SAMP_TIMER = 3'h2;
  localparam logic [2:0] MTS_SAMP_LINE = 3'h3;
  localparam logic [2:0] MTS_SAMP_LEVEL = 3'h4;
  localparam logic [2:0] MTS_SAMP_REQ = 3'h5;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  // CTRL: arm [2:0], trig [5:3], samp [8:6], level_ok [9]
  localparam int MTS_CTRL_W = 10;
  localparam int MTS_COUNT_W = 16;
  localparam int MTS_TIMER_W = 24;
  localparam int MTS_CMD_ARM_BIT = 0;
  localparam int MTS_CMD_TRIG_BIT = 1;
  localparam int MTS_IRQ_READ = 0;
  localparam int MTS_IRQ_DONE = 1;
  localparam int MTS_IRQ_ERR = 2;
  localparam int MTS_IRQ_W = 3;
  localparam logic [15:0] MTS_COUNT_RST = 16'h0001;
  localparam logic [23:0] MTS_TIMER_RST = 24'h000001;
  localparam logic [2:0] MTS_IRQ_MASK_RST = 3'h0;

  typedef struct packed {
    logic level_ok;
    logic [2:0] samp;
    logic [2:0] trig;
    logic [2:0] arm;
  } mts_cfg_t;

  localparam mts_cfg_t MTS_CFG_RST = '{level_ok: 1'b0, samp: MTS_SAMP_AUTO,
                                       trig: MTS_TRIG_AUTO, arm: MTS_ARM_HOLD};

  // Detector pulses, one cycle each for ext, level and line; req is the data_request level gated by out_buf_empty and the memory levels
  typedef struct packed {
    logic req;
    logic line;
    logic level;
    logic ext;
  } mts_evt_t;
endpackage
`default_nettype wire

// ### src/mts_edge_sync.sv
// Two-stage synchroniser with rise and fall pulse per bit
`default_nettype none
module mts_edge_sync #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] last;

  // ****************************************
  // Per-bit synchroniser and edge detect
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta[i] <= 1'b1;
        sync[i] <= 1'b1;
        last[i] <= 1'b1;
      end else begin
        meta[i] <= d[i];
        sync[i] <= meta[i];
        last[i] <= sync[i];
      end
    end
    assign rise[i] = sync[i] & ~last[i];
    assign fall[i] = ~sync[i] & last[i];
  end
endmodule
`default_nettype wire

// ### src/mts_sequencer.sv
// Measurement trigger sequencer with APB registers and interrupt
`default_nettype none
module mts_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trig_n,
  input wire logic level_hit,
  input wire logic line_zero,
  input wire logic data_request,
  input wire logic out_buf_empty,
  input wire logic mem_on,
  input wire logic mem_empty,
  output logic sample_strobe,
  output logic irq
);
  typedef enum logic [1:0] {ST_ARM, ST_TRIG, ST_SAMP} mts_state_t;

  mts_pkg::mts_cfg_t cfg;
  mts_pkg::mts_cfg_t new_cfg;
  mts_pkg::mts_evt_t evt;
  mts_state_t state;
  mts_state_t next_state;
  logic [15:0] count_n;
  logic [15:0] taken;
  logic [15:0] next_taken;
  logic [23:0] timer_n;
  logic [23:0] tcnt;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [2:0] rise;
  logic [2:0] fall;
  logic err_flag;

  // ****************************************
  // Legality of an event combination
  // ****************************************
  function automatic logic mts_legal(mts_pkg::mts_cfg_t c);
    logic ok;
    ok = 1'b1;
    if (c.arm > mts_pkg::MTS_ARM_HOLD || c.trig > mts_pkg::MTS_TRIG_HOLD ||
        c.samp > mts_pkg::MTS_SAMP_REQ) begin
      ok = 1'b0;
    end
    if (c.trig == mts_pkg::MTS_TRIG_EXT && c.samp == mts_pkg::MTS_SAMP_REQ) begin
      ok = 1'b0;
    end
    if (c.trig == mts_pkg::MTS_TRIG_LEVEL && (c.samp == mts_pkg::MTS_SAMP_REQ ||
        c.samp == mts_pkg::MTS_SAMP_LINE)) begin
      ok = 1'b0;
    end
    if (c.trig == mts_pkg::MTS_TRIG_LINE && (c.samp == mts_pkg::MTS_SAMP_REQ ||
        c.samp == mts_pkg::MTS_SAMP_LEVEL)) begin
      ok = 1'b0;
    end
    if (c.trig == mts_pkg::MTS_TRIG_ONE && (c.arm == mts_pkg::MTS_ARM_EXT ||
        c.arm == mts_pkg::MTS_ARM_ONE)) begin
      ok = 1'b0;
    end
    if ((c.trig == mts_pkg::MTS_TRIG_LEVEL || c.samp == mts_pkg::MTS_SAMP_LEVEL) &&
        !c.level_ok) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite & pready;
  wire sel_ctrl = paddr == mts_pkg::MTS_CTRL_OFS;
  wire sel_count = paddr == mts_pkg::MTS_COUNT_OFS;
  wire sel_timer = paddr == mts_pkg::MTS_TIMER_OFS;
  wire sel_cmd = paddr == mts_pkg::MTS_CMD_OFS;
  wire sel_status = paddr == mts_pkg::MTS_STATUS_OFS;
  wire sel_istat = paddr == mts_pkg::MTS_IRQ_STAT_OFS;
  wire sel_imask = paddr == mts_pkg::MTS_IRQ_MASK_OFS;
  wire addr_hit = sel_ctrl | sel_count | sel_timer | sel_cmd | sel_status |
                  sel_istat | sel_imask;
  wire ctrl_wr = apb_wr & sel_ctrl;
  wire arm_cmd = apb_wr & sel_cmd & pwdata[mts_pkg::MTS_CMD_ARM_BIT];
  wire trig_cmd = apb_wr & sel_cmd & pwdata[mts_pkg::MTS_CMD_TRIG_BIT];
  wire new_legal = mts_legal(new_cfg);
  wire cfg_ok = mts_legal(cfg);
  assign new_cfg = mts_pkg::mts_cfg_t'(pwdata[mts_pkg::MTS_CTRL_W-1:0]);
  assign irq_clr = (apb_wr & sel_istat) ? pwdata[mts_pkg::MTS_IRQ_W-1:0] : 3'h0;

  wire [31:0] status_word = {taken, 12'h000, err_flag, state == ST_SAMP,
                             state == ST_TRIG, state == ST_ARM};
  wire [31:0] rd_mux =
    sel_ctrl ? {22'h000000, cfg} :
    sel_count ? {16'h0000, count_n} :
    sel_timer ? {8'h00, timer_n} :
    sel_status ? status_word :
    sel_istat ? {29'h00000000, irq_stat} :
    sel_imask ? {29'h00000000, irq_mask} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= ~addr_hit;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  wire done_now;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= mts_pkg::MTS_CFG_RST;
    end else if (ctrl_wr) begin
      if (new_legal) begin
        cfg <= new_cfg;
      end
    end else if (done_now) begin
      if (cfg.arm == mts_pkg::MTS_ARM_ONE) begin
        cfg.arm <= mts_pkg::MTS_ARM_HOLD;
      end
      if (cfg.trig == mts_pkg::MTS_TRIG_ONE) begin
        cfg.trig <= mts_pkg::MTS_TRIG_HOLD;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_n <= mts_pkg::MTS_COUNT_RST;
      timer_n <= mts_pkg::MTS_TIMER_RST;
      irq_mask <= mts_pkg::MTS_IRQ_MASK_RST;
    end else if (apb_wr) begin
      if (sel_count) begin
        count_n <= pwdata[mts_pkg::MTS_COUNT_W-1:0];
      end
      if (sel_timer) begin
        timer_n <= pwdata[mts_pkg::MTS_TIMER_W-1:0];
      end
      if (sel_imask) begin
        irq_mask <= pwdata[mts_pkg::MTS_IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // Event detectors
  // ****************************************
  mts_edge_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({line_zero, level_hit, ext_trig_n}),
    .rise(rise),
    .fall(fall)
  );

  assign evt.ext = fall[0];
  assign evt.level = rise[1];
  assign evt.line = rise[2];
  assign evt.req = data_request & out_buf_empty & (~mem_on | mem_empty);

  wire timer_tick = tcnt + 24'h000001 >= timer_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 24'h000000;
    end else if (state != ST_SAMP || timer_tick) begin
      tcnt <= 24'h000000;
    end else begin
      tcnt <= tcnt + 24'h000001;
    end
  end

  // ****************************************
  // Event selection
  // ****************************************
  wire arm_hit =
    cfg.arm == mts_pkg::MTS_ARM_AUTO ? 1'b1 :
    cfg.arm == mts_pkg::MTS_ARM_EXT ? evt.ext :
    cfg.arm == mts_pkg::MTS_ARM_ONE ? arm_cmd : 1'b0;

  wire trig_hit =
    cfg.trig == mts_pkg::MTS_TRIG_AUTO ? 1'b1 :
    cfg.trig == mts_pkg::MTS_TRIG_EXT ? evt.ext :
    cfg.trig == mts_pkg::MTS_TRIG_LEVEL ? evt.level :
    cfg.trig == mts_pkg::MTS_TRIG_LINE ? evt.line :
    cfg.trig == mts_pkg::MTS_TRIG_REQ ? evt.req :
    cfg.trig == mts_pkg::MTS_TRIG_ONE ? trig_cmd : 1'b0;

  wire samp_hit =
    cfg.samp == mts_pkg::MTS_SAMP_AUTO ? 1'b1 :
    cfg.samp == mts_pkg::MTS_SAMP_EXT ? evt.ext :
    cfg.samp == mts_pkg::MTS_SAMP_TIMER ? timer_tick :
    cfg.samp == mts_pkg::MTS_SAMP_LINE ? evt.line :
    cfg.samp == mts_pkg::MTS_SAMP_LEVEL ? evt.level :
    cfg.samp == mts_pkg::MTS_SAMP_REQ ? evt.req : 1'b0;

  // One request satisfies both on_request events at once
  wire both_req = cfg.trig == mts_pkg::MTS_TRIG_REQ &&
                  cfg.samp == mts_pkg::MTS_SAMP_REQ;
  wire run_ok = cfg_ok && !ctrl_wr;
  wire take_now = run_ok && ((state == ST_SAMP && samp_hit) ||
                  (state == ST_TRIG && trig_hit && both_req));
  assign next_taken = taken + 16'h0001;
  assign done_now = take_now && next_taken >= count_n;

  // ****************************************
  // Sequence state machine
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_ARM: begin
        if (arm_hit) begin
          next_state = ST_TRIG;
        end
      end
      ST_TRIG: begin
        if (trig_hit) begin
          next_state = both_req && done_now ? ST_ARM : ST_SAMP;
        end
      end
      ST_SAMP: begin
        if (done_now) begin
          next_state = ST_ARM;
        end
      end
    endcase
    if (!run_ok) begin
      next_state = ST_ARM;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_ARM;
      taken <= 16'h0000;
      sample_strobe <= 1'b0;
    end else begin
      state <= next_state;
      sample_strobe <= take_now;
      if (!run_ok || done_now) begin
        taken <= 16'h0000;
      end else if (take_now) begin
        taken <= next_taken;
      end
    end
  end

  // ****************************************
  // Interrupts and refusal flag
  // ****************************************
  assign irq_set = {ctrl_wr & ~new_legal, done_now, take_now};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
      err_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq <= |(irq_stat & irq_mask);
      if (ctrl_wr) begin
        err_flag <= ~new_legal;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_arm_hold_quiet: assert property (
    cfg.arm == mts_pkg::MTS_ARM_HOLD |=> !sample_strobe)
    else $error("reading taken while arm is hold");

  a_trig_hold_quiet: assert property (
    cfg.trig == mts_pkg::MTS_TRIG_HOLD |=> !sample_strobe)
    else $error("reading taken while trigger is hold");

  a_cfg_always_legal: assert property (
    cfg_ok)
    else $error("illegal combination stored");

  a_refuse_flag: assert property (
    ctrl_wr && !new_legal |=> irq_stat[mts_pkg::MTS_IRQ_ERR] && err_flag &&
    cfg == $past(cfg))
    else $error("illegal combination not refused");

  a_one_shot_hold: assert property (
    done_now && !ctrl_wr && cfg.arm == mts_pkg::MTS_ARM_ONE |=>
    cfg.arm == mts_pkg::MTS_ARM_HOLD && state == ST_ARM)
    else $error("one-shot arm did not fall back to hold");

  a_first_on_request: assert property (
    state == ST_TRIG && take_now |-> evt.req && both_req)
    else $error("first reading without data request");

  a_arm_no_sample: assert property (
    state == ST_ARM && arm_hit && run_ok |=> state == ST_TRIG ##1 (!sample_strobe || both_req))
    else $error("arm event did not lead to trigger wait");

  a_count_bound: assert property (
    sample_strobe |-> taken < $past(count_n) || taken == 16'h0000)
    else $error("reading count overrun");

  a_req_gated: assert property (
    evt.req |-> out_buf_empty && (!mem_on || mem_empty))
    else $error("on_request without empty buffers");

  a_irq_level: assert property (
    (|(irq_stat & irq_mask)) [*2] |-> irq)
    else $error("interrupt not raised");

  c_ext_ext: cover property (
    cfg.arm == mts_pkg::MTS_ARM_EXT && cfg.trig == mts_pkg::MTS_TRIG_EXT && sample_strobe);
  c_one_shot_done: cover property (
    cfg.arm == mts_pkg::MTS_ARM_ONE && done_now);
  c_both_req: cover property (
    state == ST_TRIG && both_req && take_now);
  c_refused: cover property (
    ctrl_wr && !new_legal);
endmodule
`default_nettype wire

// ### bench/mts_far_model.sv
// Outside event sources and buffer levels facing the sequencer
`default_nettype none
module mts_far_model (
  input wire logic pclk,
  output logic ext_trig_n,
  output logic level_hit,
  output logic line_zero,
  output logic data_request,
  output logic out_buf_empty,
  output logic mem_on,
  output logic mem_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_trig_n = 1'b1;
    level_hit = 1'b0;
    line_zero = 1'b0;
    data_request = 1'b0;
    out_buf_empty = 1'b1;
    mem_on = 1'b0;
    mem_empty = 1'b1;
  end
  // ****************************************
  // Buffer levels seen by the request gate
  // ****************************************
  task automatic set_bufs(input logic be, input logic mo, input logic me);
    @(posedge pclk);
    out_buf_empty <= be;
    mem_on <= mo;
    mem_empty <= me;
  endtask
  // ****************************************
  // Events: 1 edge, 2 level, 3 line, 4 request
  // ****************************************
  task automatic fire(input int code);
    @(posedge pclk);
    case (code)
      1: ext_trig_n <= 1'b0;
      2: level_hit <= 1'b1;
      3: line_zero <= 1'b1;
      4: data_request <= 1'b1;
      default: ;
    endcase
    repeat (code == 4 ? 1 : 4) @(posedge pclk);
    ext_trig_n <= 1'b1;
    level_hit <= 1'b0;
    line_zero <= 1'b0;
    data_request <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/measurement_trigger_sequencer_tb.sv
// Self-checking bench of the measurement trigger sequencer
`default_nettype none
module measurement_trigger_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] a, t, s;
    logic lok, bad;
    int e1, e2, n1, n2;
  } mts_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_strobe, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ext_trig_n, level_hit, line_zero, data_request, out_buf_empty, mem_on, mem_empty;
  int fails, n_checks, n_strobe;
  // Row: arm, trig, samp, level_ok, refused, event1, event2, strobes after each
  mts_row_t rows [22] = '{
    '{3'h1, 3'h0, 3'h0, 0, 0, 1, 0, 2, 2},
    '{3'h1, 3'h1, 3'h0, 0, 0, 1, 1, 0, 2},
    '{3'h1, 3'h1, 3'h5, 0, 1, 1, 1, 0, 0},
    '{3'h1, 3'h2, 3'h0, 1, 0, 1, 2, 0, 2},
    '{3'h1, 3'h2, 3'h3, 1, 1, 1, 2, 0, 0},
    '{3'h1, 3'h3, 3'h0, 0, 0, 1, 3, 0, 2},
    '{3'h1, 3'h3, 3'h4, 1, 1, 1, 3, 0, 0},
    '{3'h1, 3'h4, 3'h5, 0, 0, 1, 4, 0, 1},
    '{3'h1, 3'h4, 3'h0, 0, 0, 1, 4, 0, 2},
    '{3'h3, 3'h0, 3'h0, 0, 0, 1, 5, 0, 0},
    '{3'h1, 3'h6, 3'h0, 0, 0, 1, 1, 0, 0},
    '{3'h2, 3'h0, 3'h0, 0, 0, 0, 5, 0, 2},
    '{3'h2, 3'h1, 3'h0, 0, 0, 5, 1, 0, 2},
    '{3'h2, 3'h1, 3'h5, 0, 1, 5, 1, 0, 0},
    '{3'h2, 3'h2, 3'h0, 1, 0, 5, 2, 0, 2},
    '{3'h2, 3'h3, 3'h0, 0, 0, 5, 3, 0, 2},
    '{3'h2, 3'h4, 3'h5, 0, 0, 5, 4, 0, 1},
    '{3'h2, 3'h5, 3'h0, 0, 1, 5, 5, 0, 0},
    '{3'h1, 3'h2, 3'h0, 0, 1, 1, 2, 0, 0},
    '{3'h2, 3'h4, 3'h0, 0, 0, 5, 4, 0, 2},
    '{3'h1, 3'h0, 3'h2, 0, 0, 1, 0, 2, 2},
    '{3'h1, 3'h0, 3'h1, 0, 0, 1, 1, 0, 1}
  };
  mts_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig_n(ext_trig_n), .level_hit(level_hit),
    .line_zero(line_zero), .data_request(data_request), .out_buf_empty(out_buf_empty),
    .mem_on(mem_on), .mem_empty(mem_empty), .sample_strobe(sample_strobe), .irq(irq));
  mts_far_model far_u (.pclk(pclk), .ext_trig_n(ext_trig_n), .level_hit(level_hit),
    .line_zero(line_zero), .data_request(data_request), .out_buf_empty(out_buf_empty),
    .mem_on(mem_on), .mem_empty(mem_empty));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (sample_strobe === 1'b1) n_strobe++;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mk(mts_row_t r);
    return {22'h0, r.lok, r.s, r.t, r.a};
  endfunction
  task automatic ev(input int code);
    if (code == 5) apb(1'b1, mts_pkg::MTS_CMD_OFS, 32'h00000001);
    else far_u.fire(code);
    repeat (12) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    mts_row_t r;
    logic [2:0] ea;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, n_strobe, fails, n_checks} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mts_pkg::MTS_CTRL_OFS, 32'h0);
    chk(rd, 32'(mts_pkg::MTS_CFG_RST));
    apb(1'b0, mts_pkg::MTS_COUNT_OFS, 32'h0);
    chk(rd, 32'(mts_pkg::MTS_COUNT_RST));
    apb(1'b0, mts_pkg::MTS_TIMER_OFS, 32'h0);
    chk(rd, 32'(mts_pkg::MTS_TIMER_RST));
    apb(1'b0, mts_pkg::MTS_IRQ_MASK_OFS, 32'h0);
    chk(rd, 32'(mts_pkg::MTS_IRQ_MASK_RST));
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], pslverr}, 32'h00000001);
    $display("test reset done");
    for (int i = 0; i < 22; i++) begin
      r = rows[i];
      apb(1'b1, mts_pkg::MTS_CTRL_OFS, 32'h00000003);
      apb(1'b1, mts_pkg::MTS_COUNT_OFS, 32'h00000002);
      apb(1'b1, mts_pkg::MTS_CTRL_OFS, mk(r));
      apb(1'b0, mts_pkg::MTS_STATUS_OFS, 32'h0);
      chk(rd[3], r.bad);
      n_strobe = 0;
      ev(r.e1);
      chk(n_strobe, r.n1);
      ev(r.e2);
      chk(n_strobe, r.n2);
      ea = r.bad ? 3'h3 : (r.a == 3'h2 && r.n2 == 2) ? 3'h3 : r.a;
      apb(1'b0, mts_pkg::MTS_CTRL_OFS, 32'h0);
      chk(rd[2:0], ea);
      $display("test row %0d done", i);
    end
    r = rows[7];
    apb(1'b1, mts_pkg::MTS_IRQ_STAT_OFS, 32'h00000007);
    apb(1'b1, mts_pkg::MTS_CTRL_OFS, mk(r));
    n_strobe = 0;
    ev(1);
    far_u.set_bufs(1'b0, 1'b0, 1'b1);
    ev(4);
    chk(n_strobe, 0);
    far_u.set_bufs(1'b1, 1'b1, 1'b0);
    ev(4);
    chk(n_strobe, 0);
    far_u.set_bufs(1'b1, 1'b1, 1'b1);
    ev(4);
    chk(n_strobe, 1);
    ev(4);
    chk(n_strobe, 2);
    $display("test request gate done");
    chk(irq, 1'b0);
    apb(1'b1, mts_pkg::MTS_IRQ_MASK_OFS, 32'h00000002);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, mts_pkg::MTS_IRQ_STAT_OFS, 32'h00000002);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("test interrupt done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({pready, pslverr, sample_strobe, irq}, 32'h00000000);
    presetn <= 1'b1;
    apb(1'b0, mts_pkg::MTS_STATUS_OFS, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, mts_pkg::MTS_IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, mts_pkg::MTS_CTRL_OFS, 32'h0);
    chk(rd, 32'(mts_pkg::MTS_CFG_RST));
    $display("test mid-run reset done");
    close_out();
  end
endmodule
`default_nettype wire
